/* File: hw/iam_pkg.sv */
// Purpose: shared constants and carriers for the index address modifier
// Assumes: one clock, digits are 4-bit bcd, zones carried separately
// Notes:   index words sit in consecutive five-digit blocks of storage
package iam_pkg;
  // storage and index word layout
  localparam int unsigned ADDR_DIGITS    = 5;
  localparam logic [15:0] IDX_BASE_ADDR  = 16'd25;   // first word, ten-thousands end
  localparam logic [15:0] IDX_LAST_ADDR  = 16'd29;
  localparam logic [15:0] IDX_WORD_SPAN  = 16'd5;
  localparam logic [3:0]  TAG_NONE       = 4'h0;
  localparam logic [3:0]  DIGIT_NINE     = 4'h9;
  localparam logic [3:0]  DIGIT_TEN      = 4'ha;
  // instruction ring steps of interest
  localparam logic [3:0]  ISTEP_H_A      = 4'h3;
  localparam logic [3:0]  ISTEP_T_A      = 4'h4;
  localparam logic [3:0]  ISTEP_IDX_A    = 4'h5;
  localparam logic [3:0]  ISTEP_H_B      = 4'h8;
  localparam logic [3:0]  ISTEP_T_B      = 4'h9;
  localparam logic [3:0]  ISTEP_IDX_B    = 4'ha;
  // position ring: one-hot, six states
  localparam int unsigned RING_LEN       = 6;
  localparam logic [5:0]  RING_RESET     = 6'h01;

  // machine cycle kind presented to the sequencer
  typedef enum logic [1:0] {
    IAM_CY_I,
    IAM_CY_X,
    IAM_CY_C,
    IAM_CY_D
  } iam_cycle_t;

  // one instruction read-out step from the sequencer
  typedef struct packed {
    logic       logic_gate_a;        // logic gate a of this step
    logic [3:0] step;       // instruction ring position
    logic [1:0] zones;      // b,a zone bits over the digit
    logic       no_idx_1st; // op forbids indexing of first address
    logic       addr_dbl;   // address-double type op code
    logic       no_b_field; // instruction has no b field
  } iam_step_t;

  // one digit read back from storage
  typedef struct packed {
    logic       valid;
    logic [3:0] digit;
    logic       minus;      // sign, meaningful on units digit only
  } iam_digit_t;
endpackage

/* File: hw/iam_index_address_modifier.sv */
// Purpose: indexes an instruction address by a stored index word
// Assumes: storage answers each digit request with one valid digit
// Notes:   negative index is added as ten's complement, carry dropped
`timescale 1ns/1ps

// Summary of operation
// - ring step two adds address units digit
// - units sign picks true or complement add
// - result digit loads a or b register
// - double ops with no b field load a, b, d together
// - ring plus tags address next index digit
// - sixth ring state adds ten-thousands digit
// - then c or d cycle updates register
// - instruction ring holds during indexing
// - after update, resume i cycles
// - hundreds tags set at steps 3 or 8
// - tens tags set at steps 4 or 9
// - exactly five index digit reads when indexed
// - trigger at step 5 a, step 10 b
// - fifteen words from location 00025 upward
// - six-state ring gates the five digits
module iam_index_address_modifier #(
  parameter int unsigned DIGITS = iam_pkg::ADDR_DIGITS
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // instruction read-out sequencer
  input  wire iam_pkg::iam_step_t  step_in,
  input  wire logic [DIGITS*4-1:0] addr_in,     // unindexed address from car or dar
  output logic                     ring_hold_q,
  output iam_pkg::iam_cycle_t      cycle_q,
  output logic                     idx_done_q,
  // storage read of index digits
  output logic                     mem_rd_q,
  output logic [15:0]              storage_address_latch_q,
  input  wire iam_pkg::iam_digit_t mem_in,
  // address registers
  output logic [DIGITS*4-1:0]      a_address_register_q,
  output logic [DIGITS*4-1:0]      b_address_register_q,
  output logic [DIGITS*4-1:0]      c_address_register_q,
  output logic [DIGITS*4-1:0]      d_address_register_q
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {
    IAM_IDLE,
    IAM_REQ,
    IAM_WAIT,
    IAM_UPD
  } iam_state_t;

  iam_state_t        state_q, state_d;   // sequencer of indexing
  logic [1:0]        tag_h_q;            // hundreds tag latches
  logic [1:0]        tag_t_q;            // tens tag latches
  logic [5:0]        ring_q;             // position ring, one hot
  logic              field_b_q;          // indexing the b field
  logic              minus_q;            // sign of index word
  logic              carry_q;            // carry into next digit
  logic [2:0]        pos_q;              // digit position being added
  logic              dbl_q;              // load a,b,d together
  logic [DIGITS*4-1:0] sum_q;            // assembled indexed address

  ////////////////////////////////////////////////////////////////////////////
  // decode
  // digit adder with complement of b side
  function automatic logic [4:0] bcd_add(input logic [3:0] a, input logic [3:0] b,
                                         input logic cin, input logic comp);
    logic [3:0] bb;
    logic [4:0] raw;
    bb  = comp ? (iam_pkg::DIGIT_NINE - b) : b;
    raw = {1'b0, a} + {1'b0, bb} + {4'h0, cin};
    if (raw >= {1'b0, iam_pkg::DIGIT_TEN}) begin
      bcd_add = {1'b1, raw[3:0] - iam_pkg::DIGIT_TEN};
    end else begin
      bcd_add = raw;
    end
  endfunction

  wire [3:0]  tag_code   = {tag_h_q, tag_t_q};          // register number 1..15
  wire        idx_needed = (tag_code != iam_pkg::TAG_NONE);
  wire        trig_a     = step_in.logic_gate_a && (step_in.step == iam_pkg::ISTEP_IDX_A);
  wire        trig_b     = step_in.logic_gate_a && (step_in.step == iam_pkg::ISTEP_IDX_B);
  wire        trig       = (trig_a || trig_b) && idx_needed;
  // tag strobes; first-address-forbidding ops latch nothing
  wire        tag_strobe = step_in.logic_gate_a && !step_in.no_idx_1st;
  wire        at_h_step  = (step_in.step == iam_pkg::ISTEP_H_A) ||
                           (step_in.step == iam_pkg::ISTEP_H_B);
  wire        at_t_step  = (step_in.step == iam_pkg::ISTEP_T_A) ||
                           (step_in.step == iam_pkg::ISTEP_T_B);
  // word base from tag; units digit at high end of block
  wire [15:0] word_base  = iam_pkg::IDX_BASE_ADDR +
                           16'(tag_code - 4'h1) * iam_pkg::IDX_WORD_SPAN;
  wire [15:0] units_loc  = word_base + (iam_pkg::IDX_LAST_ADDR - iam_pkg::IDX_BASE_ADDR);
  // ring position picks the digit location
  wire [15:0] digit_loc  = units_loc - 16'(pos_q);
  wire [3:0]  a_digit    = addr_in[pos_q*4 +: 4];
  // sign on units digit selects complement
  wire        comp_now   = (pos_q == 3'd0) ? mem_in.minus : minus_q;
  // carry in for complement starts at one
  wire        cin_now    = (pos_q == 3'd0) ? mem_in.minus : carry_q;
  wire [4:0]  digit_sum  = bcd_add(a_digit, mem_in.digit, cin_now, comp_now);
  // sixth ring state marks the ten-thousands digit
  // six-state ring fixes the digit count at five
  wire        last_pos   = ring_q[iam_pkg::RING_LEN-1];
  wire [DIGITS*4-1:0] sum_next = sum_q | ({{(DIGITS*4-4){1'b0}}, digit_sum[3:0]} << (pos_q*4));

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      IAM_IDLE: begin
        if (trig) begin
          state_d = IAM_REQ;
        end
      end
      IAM_REQ:  state_d = IAM_WAIT;
      IAM_WAIT: begin
        if (mem_in.valid) begin
          state_d = last_pos ? IAM_UPD : IAM_REQ;
        end
      end
      IAM_UPD:  state_d = IAM_IDLE;
      default:  state_d = IAM_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // tag latches, cleared when the update completes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tag_h_q <= 2'h0;
      tag_t_q <= 2'h0;
    end else begin
      // hundreds tags; a new tag beats the clear
      if (tag_strobe && at_h_step) begin
        tag_h_q <= step_in.zones;
      end else if (state_q == IAM_UPD) begin
        tag_h_q <= 2'h0;
      end
      // tens tags; same priority as hundreds
      if (tag_strobe && at_t_step) begin
        tag_t_q <= step_in.zones;
      end else if (state_q == IAM_UPD) begin
        tag_t_q <= 2'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // position ring and adder state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= IAM_IDLE;
      ring_q    <= iam_pkg::RING_RESET;
      pos_q     <= 3'h0;
      field_b_q <= 1'b0;
      minus_q   <= 1'b0;
      carry_q   <= 1'b0;
      dbl_q     <= 1'b0;
      sum_q     <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == IAM_IDLE && trig) begin
        // ring leaves state one on entry
        ring_q    <= {ring_q[4:0], ring_q[5]};
        pos_q     <= 3'h0;
        field_b_q <= trig_b;
        dbl_q     <= step_in.addr_dbl && step_in.no_b_field;
        sum_q     <= '0;
      end else if (state_q == IAM_WAIT && mem_in.valid) begin
        // ripple carry to next x cycle
        carry_q <= digit_sum[4];
        sum_q   <= sum_next;
        if (pos_q == 3'd0) begin
          minus_q <= mem_in.minus;
        end
        ring_q <= last_pos ? iam_pkg::RING_RESET : {ring_q[4:0], ring_q[5]};
        pos_q  <= last_pos ? 3'h0 : pos_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward sequencer and storage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ring_hold_q             <= 1'b0;
      cycle_q                 <= iam_pkg::IAM_CY_I;
      idx_done_q              <= 1'b0;
      mem_rd_q                <= 1'b0;
      storage_address_latch_q <= 16'h0000;
    end else begin
      ring_hold_q <= (state_d != IAM_IDLE);
      // c for a field, d for b field
      cycle_q     <= (state_d == IAM_UPD) ? (field_b_q ? iam_pkg::IAM_CY_D : iam_pkg::IAM_CY_C) :
                     (state_d == IAM_IDLE) ? iam_pkg::IAM_CY_I : iam_pkg::IAM_CY_X;
      idx_done_q  <= (state_q == IAM_UPD);
      mem_rd_q    <= (state_q == IAM_REQ);
      if (state_q == IAM_REQ) begin
        storage_address_latch_q <= digit_loc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address registers; top digit carry is simply not stored
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      a_address_register_q <= '0;
      b_address_register_q <= '0;
      c_address_register_q <= '0;
      d_address_register_q <= '0;
    end else if (state_q == IAM_WAIT && mem_in.valid) begin
      // result digit into a or b register
      if (!field_b_q || dbl_q) begin
        a_address_register_q <= sum_next;
      end
      if (field_b_q || dbl_q) begin
        b_address_register_q <= sum_next;
      end
      if (dbl_q) begin
        d_address_register_q <= sum_next;
      end
    end else if (state_q == IAM_UPD) begin
      // update cycle rewrites c or d
      if (field_b_q) begin
        d_address_register_q <= sum_q;
      end else begin
        c_address_register_q <= sum_q;
      end
    end
  end

endmodule

/* File: verification/iam_chk_sva.sv */
// Purpose: port checks for the index modifier
// Assumes: one clock, async low reset
// Notes:   a helper counts digits per sequence
`timescale 1ns/1ps
module iam_chk #(parameter int unsigned DIGITS = 5) (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                resetn,
  // sequencer side
  input wire iam_pkg::iam_step_t  step_in,
  input wire logic [DIGITS*4-1:0] addr_in,
  input wire logic                ring_hold_q,
  input wire iam_pkg::iam_cycle_t cycle_q,
  input wire logic                idx_done_q,
  // storage side
  input wire logic                mem_rd_q,
  input wire logic [15:0]         storage_address_latch_q,
  input wire iam_pkg::iam_digit_t mem_in,
  // address registers
  input wire logic [DIGITS*4-1:0] a_address_register_q,
  input wire logic [DIGITS*4-1:0] b_address_register_q,
  input wire logic [DIGITS*4-1:0] c_address_register_q,
  input wire logic [DIGITS*4-1:0] d_address_register_q
);
  logic [2:0] vcnt_q; // digits answered so far
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // cleared whenever idle so a stray digit cannot carry over
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) vcnt_q <= 3'h0;
    else if (!ring_hold_q) vcnt_q <= 3'h0;
    else if (mem_in.valid) vcnt_q <= vcnt_q + 3'h1;
  end
  ////////////////////////////////////////////////////////////
  property p_trig;
    $rose(ring_hold_q) |-> $past(step_in.logic_gate_a) && ($past(step_in.step) == iam_pkg::ISTEP_IDX_A
      || $past(step_in.step) == iam_pkg::ISTEP_IDX_B);
  endproperty
  a_trig: assert property (p_trig) else $error("hold without trigger step");
  property p_rd1; $rose(ring_hold_q) |-> ##1 mem_rd_q; endproperty
  a_rd1: assert property (p_rd1) else $error("first digit not read");
  property p_rdn; mem_in.valid && ring_hold_q && vcnt_q < 3'h4 |-> ##2 mem_rd_q; endproperty
  a_rdn: assert property (p_rdn) else $error("next digit not read");
  property p_loc;
    $rose(ring_hold_q) |-> ##1 storage_address_latch_q inside {[16'd29:16'd99]}
      && (storage_address_latch_q - 16'd29) % 16'd5 == 16'd0;
  endproperty
  a_loc: assert property (p_loc) else $error("units location wrong");
  property p_five; cycle_q inside {iam_pkg::IAM_CY_C, iam_pkg::IAM_CY_D} |-> vcnt_q == 3'h5;
  endproperty
  a_five: assert property (p_five) else $error("update before five digits");
  property p_end;
    cycle_q inside {iam_pkg::IAM_CY_C, iam_pkg::IAM_CY_D}
      |=> idx_done_q && cycle_q == iam_pkg::IAM_CY_I && !ring_hold_q;
  endproperty
  a_end: assert property (p_end) else $error("no return to i cycles");
  property p_hold; ring_hold_q |-> cycle_q != iam_pkg::IAM_CY_I; endproperty
  a_hold: assert property (p_hold) else $error("i cycle while held");
  property p_cupd;
    cycle_q == iam_pkg::IAM_CY_C |=> c_address_register_q == $past(a_address_register_q);
  endproperty
  a_cupd: assert property (p_cupd) else $error("c register not updated");
endmodule
bind iam_index_address_modifier iam_chk #(.DIGITS(DIGITS)) u_chk (.*);

/* File: verification/iam_storage_model.sv */
// Purpose: core storage answering index digit reads
// Assumes: one request outstanding at a time
// Notes:   slow adds three wait cycles per digit
`timescale 1ns/1ps
module iam_storage_model (
  // clock and reset
  input wire logic            ref_clk,
  input wire logic            resetn,
  // read request from the block
  input wire logic            mem_rd_q,
  input wire logic [15:0]     storage_address_latch_q,
  input wire logic            slow,
  // digit answer
  output iam_pkg::iam_digit_t mem_in
);
  logic [3:0]  dig [0:99]; // index words at 25..99
  logic        neg [0:99];
  logic [15:0] loc_q;
  logic [1:0]  wait_q;
  logic        pend_q;
  // released lines invert each cycle, showing the last digit every other cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= 1'b0;
      mem_in <= '0;
    end else begin
      mem_in <= '{1'b0, ~mem_in.digit, ~mem_in.minus};
      if (mem_rd_q) begin
        pend_q <= 1'b1;
        loc_q <= storage_address_latch_q;
        wait_q <= slow ? 2'h3 : 2'h0;
      end else if (pend_q && wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      else if (pend_q) begin
        pend_q <= 1'b0;
        mem_in <= '{1'b1, dig[loc_q[6:0]], neg[loc_q[6:0]]};
      end
    end
  end
endmodule

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the index modifier
// Assumes: storage model on the digit side
// Notes:   expectations from decimal sums mod 100000
`timescale 1ns/1ps
module tb_top;
  logic                ref_clk = 1'b0;
  logic                resetn = 1'b0;
  logic                slow = 1'b0;
  iam_pkg::iam_step_t  step_in = '0;
  logic [19:0]         addr_in = '0;
  logic                hold, done, rd;
  iam_pkg::iam_cycle_t cyc;
  logic [15:0]         sal;
  iam_pkg::iam_digit_t mem_in;
  logic [19:0]         a_q, b_q, c_q, d_q;
  int                  fail_count = 0;
  int                  num_checks = 0;
  always #2 ref_clk = ~ref_clk;
  iam_index_address_modifier uut (.ref_clk(ref_clk), .resetn(resetn), .step_in(step_in),
    .addr_in(addr_in), .ring_hold_q(hold), .cycle_q(cyc), .idx_done_q(done), .mem_rd_q(rd),
    .storage_address_latch_q(sal), .mem_in(mem_in), .a_address_register_q(a_q),
    .b_address_register_q(b_q), .c_address_register_q(c_q), .d_address_register_q(d_q));
  iam_storage_model st (.ref_clk(ref_clk), .resetn(resetn), .mem_rd_q(rd),
    .storage_address_latch_q(sal), .slow(slow), .mem_in(mem_in));
  ////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [19:0] s, input logic [19:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic int val(input logic [19:0] x);
    int v;
    v = 0;
    for (int i = 4; i >= 0; i--) v = v * 10 + int'(x[4*i+:4]);
    return v;
  endfunction
  function automatic logic [19:0] bcd(input int v);
    logic [19:0] r;
    for (int i = 0; i < 5; i++) begin
      r[4*i+:4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction
  // steps 3/4/5 or 8/9/10 with tags, then watch for completion
  task automatic run(input logic bf, input logic [3:0] tg, input logic [2:0] fl,
                     output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      step_in <= '{1'b1, (bf ? 4'h8 : 4'h3) + 4'(i), i == 0 ? tg[3:2] : tg[1:0],
                   fl[2], fl[1], fl[0]};
    end
    @(posedge ref_clk);
    step_in <= '0;
    repeat (50) begin
      @(posedge ref_clk);
      #1 if (done === 1'b1) seen = 1'b1;
    end
  endtask
  // loads word n, indexes addr, judges the updated registers
  task automatic idx(input logic bf, input int n, input logic [19:0] ad, input logic [19:0] w,
                     input logic ng, input logic [2:0] fl);
    logic        s;
    logic [19:0] e;
    for (int i = 0; i < 5; i++) st.dig[29+5*(n-1)-i] = w[4*i+:4];
    st.neg[29+5*(n-1)] = ng;
    @(posedge ref_clk);
    addr_in <= ad;
    e = bcd((val(ad) + (ng ? 100000 - val(w) : val(w))) % 100000);
    run(bf, 4'(n), fl, s);
    check("done", {19'h0, s}, 20'h1);
    check("ab", bf ? b_q : a_q, e);
    check("cd", bf ? d_q : c_q, e);
    if (fl[1]) check("dbl_b", b_q, e);
    if (fl[1]) check("dbl_d", d_q, e);
  endtask
  task automatic t_pos(); idx(1'b0, 1, 20'h07001, 20'h00080, 1'b0, 3'h0); endtask
  task automatic t_neg(); slow <= 1'b1; idx(1'b1, 15, 20'h00100, 20'h00001, 1'b1, 3'h0); endtask
  task automatic t_wrap(); idx(1'b0, 7, 20'h99999, 20'h00001, 1'b0, 3'h0); endtask
  task automatic t_dbl(); idx(1'b0, 8, 20'h00350, 20'h01234, 1'b0, 3'h3); endtask
  // forbidden first address and untagged field take no x cycles
  task automatic t_none();
    logic s;
    run(1'b0, 4'h9, 3'h4, s);
    check("forbid", {19'h0, s}, 20'h0);
    run(1'b1, 4'h0, 3'h0, s);
    check("untag", {19'h0, s}, 20'h0);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1 check("rst_a", a_q, 20'h0);
    check("rst_cyc", {18'h0, cyc}, 20'h0);
    t_pos();
    t_neg();
    t_wrap();
    t_dbl();
    t_none();
    finish_test();
  end
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule
